//--- dv/tb_timer_counter_status_control.sv
// Self-checking bench for the timer counter status/control block.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module tb_timer_counter_status_control;
  import tmr_pkg::*;
  logic mclk = 0, rst = 1, ext_clk = 0, fixed_clk_en = 0, loop_enabled = 0;
  logic debug_halt_mode = 0, count_down, center_align_select;
  logic counter_enabled, irq;
  logic [15:0] modulo_value = 16'h0000, count_value, cv;
  logic [7:0] rd;
  logic [2:0] tick = 3'h0, ps;
  logic [1:0] cs;
  av_req_t av_req = '0;
  av_rsp_t av_rsp;
  int n_fail = 0, num_checks = 0, k, sh;
  timer_counter_status_control u_timer_counter_status_control (.mclk, .rst,
    .av_req, .av_rsp, .ext_clk, .fixed_clk_en, .loop_enabled,
    .debug_halt_mode, .modulo_value, .count_value, .count_down,
    .center_align_select, .counter_enabled, .irq);
  // Clock; the external source edges every 8 cycles, well under a quarter.
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    tick <= tick + 3'h1;
    ext_clk <= tick[2];
    fixed_clk_en <= ~fixed_clk_en;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(logic wr, logic [1:0] a, logic [7:0] d);
    @(posedge mclk);
    av_req <= '{a, ~wr, wr, {24'h000000, d}};
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (av_rsp.waitrequest === 1'b0) break;
      if (i == 19) begin n_fail++; give_verdict(); end
    end
    rd = av_rsp.readdata[7:0];
    av_req <= '0;
  endtask : bus
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (s === 1'b1) break;
      if (i == 299) begin n_fail++; give_verdict(); end
    end
  endtask : wait_hi
  initial begin
    k = $urandom(39);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      bus(0, k[1:0], 8'h00);
      chk("reset", rd, 8'h00);
    end
    // Sources and prescale; sh is the total division as a shift.
    for (k = 0; k < 11; k++) begin
      cs = k < 8 ? 2'h1 : (k < 10 ? 2'h2 : 2'h3);
      ps = k < 8 ? k[2:0] : (k == 9 ? 3'h1 : 3'h0);
      sh = ps + (k == 9) + (k == 10 ? 3 : 0);
      loop_enabled <= k == 9;
      bus(1, `TMR_ADDR_SC, {3'h0, cs, ps});
      bus(1, `TMR_ADDR_CNTL, 8'($urandom));
      repeat (16 << sh) @(posedge mclk);
      chk("rate", count_value >= 16'h000D && count_value <= 16'h0011, 1);
    end
    $display("test rates done");
    // Coherent byte reads and what restarts the holding latch.
    bus(1, `TMR_ADDR_SC, 8'h08);
    bus(1, `TMR_ADDR_CNTH, 8'($urandom));
    bus(0, `TMR_ADDR_CNTL, 8'h00);
    repeat (300) @(posedge mclk);
    bus(0, `TMR_ADDR_CNTH, 8'h00);
    chk("held high", rd, 8'h00);
    bus(0, `TMR_ADDR_CNTH, 8'h00);
    chk("live high", rd, 8'h01);
    repeat (300) @(posedge mclk);
    bus(1, `TMR_ADDR_CNTL, 8'($urandom));
    bus(0, `TMR_ADDR_CNTH, 8'h00);
    chk("after clear", rd, 8'h00);
    repeat (300) @(posedge mclk);
    bus(1, `TMR_ADDR_SC, 8'h08);
    bus(0, `TMR_ADDR_CNTH, 8'h00);
    chk("after sc write", rd, 8'h01);
    repeat (300) @(posedge mclk);
    debug_halt_mode <= 1'b1;
    repeat (8) @(posedge mclk);
    cv = count_value;
    repeat (50) @(posedge mclk);
    chk("frozen", count_value, cv);
    bus(1, `TMR_ADDR_SC, 8'h08);
    bus(0, `TMR_ADDR_CNTH, 8'h00);
    chk("halt high", rd, cv[15:8]);
    bus(0, `TMR_ADDR_CNTL, 8'h00);
    chk("halt low", rd, cv[7:0]);
    debug_halt_mode <= 1'b0;
    $display("test reads done");
    // Overflow flag, its clearing sequence and the interrupt line.
    modulo_value <= 16'h0020 + 16'($urandom % 32);
    bus(1, `TMR_ADDR_SC, 8'h48);
    bus(1, `TMR_ADDR_CNTL, 8'h00);
    wait_hi(irq);
    bus(0, `TMR_ADDR_SC, 8'h00);
    chk("flag", rd, 8'hC8);
    bus(1, `TMR_ADDR_SC, 8'hC8);
    bus(0, `TMR_ADDR_SC, 8'h00);
    chk("one kept", rd, 8'hC8);
    bus(1, `TMR_ADDR_SC, 8'h48);
    bus(0, `TMR_ADDR_SC, 8'h00);
    chk("cleared", rd, 8'h48);
    chk("irq off", irq, 1'b0);
    wait_hi(irq);
    bus(0, `TMR_ADDR_SC, 8'h00);
    repeat (70) @(posedge mclk);
    bus(1, `TMR_ADDR_SC, 8'h48);
    bus(0, `TMR_ADDR_SC, 8'h00);
    chk("restart", rd, 8'hC8);
    bus(1, `TMR_ADDR_SC, 8'h08);
    repeat (70) @(posedge mclk);
    chk("masked", irq, 1'b0);
    bus(1, `TMR_ADDR_IRQ, 8'h02);
    @(posedge mclk);
    chk("status irq", irq, 1'b1);
    bus(1, `TMR_ADDR_IRQ, 8'h03);
    @(posedge mclk);
    chk("status clr", irq, 1'b0);
    bus(1, `TMR_ADDR_IRQ, 8'h00);
    $display("test overflow done");
    // Center-aligned counting turns at the modulo value.
    modulo_value <= 16'h0010;
    bus(1, `TMR_ADDR_SC, 8'h28);
    wait_hi(count_down);
    chk("top", count_value <= 16'h0010, 1);
    $display("test center done");
    give_verdict();
  end
endmodule : tb_timer_counter_status_control
bind timer_counter_status_control timer_counter_chk u_timer_counter_chk (
  .mclk, .rst, .av_req, .av_rsp, .debug_halt_mode, .modulo_value,
  .count_value, .count_down, .center_align_select, .counter_enabled, .irq);

//--- dv/timer_counter_chk.sv
// Port-level checker for the timer counter status/control block.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module timer_counter_chk (
  // Clock, reset and bus.
  input wire logic mclk,
  input wire logic rst,
  input wire tmr_pkg::av_req_t av_req,
  input wire tmr_pkg::av_rsp_t av_rsp,
  // Counter side.
  input wire logic debug_halt_mode,
  input wire logic [15:0] modulo_value,
  input wire logic [15:0] count_value,
  input wire logic count_down,
  input wire logic center_align_select,
  input wire logic counter_enabled,
  input wire logic irq
);
  import tmr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic req, sc_wr, cnt_wr;
  logic [1:0] a;
  // Accepted writes only, so a held request never counts twice.
  assign a = av_req.address;
  assign req = av_req.read | av_req.write;
  assign sc_wr = av_req.write & ~av_rsp.waitrequest & a == `TMR_ADDR_SC;
  assign cnt_wr = av_req.write & ~av_rsp.waitrequest &
    (a == `TMR_ADDR_CNTH | a == `TMR_ADDR_CNTL);
  chk_one_wait: assert property (req && av_rsp.waitrequest |=>
    !av_rsp.waitrequest) else $error("bus answer late");
  chk_cnt_clear: assert property (cnt_wr |=> count_value == 16'h0000)
    else $error("counter not cleared by write");
  chk_halt_hold: assert property (debug_halt_mode [*4] ##0 !$past(cnt_wr)
    |-> $stable(count_value)) else $error("counter moved in halt");
  chk_off_hold: assert property (!counter_enabled [*2] ##0 !$past(cnt_wr)
    |-> $stable(count_value)) else $error("counter moved while off");
  chk_cnt_step: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000
    || count_value == $past(count_value) - 16'h0001)
    else $error("counter jumped");
  chk_mod_wrap: assert property (!center_align_select &&
    modulo_value != 16'h0000 && count_value == modulo_value ##1
    $changed(count_value) |-> count_value == 16'h0000)
    else $error("no wrap at modulo");
  chk_ca_follow: assert property (sc_wr |=>
    center_align_select == $past(av_req.writedata[5]))
    else $error("center select wrong");
  chk_en_follow: assert property (sc_wr |=>
    counter_enabled == ($past(av_req.writedata[4:3]) != 2'h0))
    else $error("enable wrong");
  cover property ($rose(irq));
  cover property ($rose(count_down));
  cover property (cnt_wr && debug_halt_mode);
endmodule : timer_counter_chk

//--- verilog/timer_counter_status_control.sv
// Timer counter with status/control, prescaler and coherent reads.
`timescale 1ns/1ns
`include "tmr_cfg.svh"
module timer_counter_status_control (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire tmr_pkg::av_req_t av_req,
  output tmr_pkg::av_rsp_t av_rsp,
  // Chip-level inputs.
  input wire logic ext_clk,
  input wire logic fixed_clk_en,
  input wire logic loop_enabled,
  input wire logic debug_halt_mode,
  input wire logic [15:0] modulo_value,
  // Outputs to channels and system.
  output logic [15:0] count_value,
  output logic count_down,
  output logic center_align_select,
  output logic counter_enabled,
  output logic irq
);
  import tmr_pkg::*;

  state_t s_r;
  state_t s_nxt;

  //----------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------
  // Prescaler tick: the low ps bits of the divider are all ones.
  function automatic logic pre_tick(input logic [6:0] pre,
                                    input logic [2:0] ps);
    logic [6:0] msk;
    msk = 7'h7F >> (3'h7 - ps);
    pre_tick = ((pre & msk) == msk);
  endfunction : pre_tick

  //----------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------
  // All next-state bus, counter and flag behaviour is computed here in one pass.
  always_comb begin
    logic wr;
    logic rd;
    logic halted;
    logic src_en;
    logic tick;
    logic ovf_evt;
    logic [15:0] top;
    wr = 1'b0;
    rd = 1'b0;
    halted = 1'b0;
    src_en = 1'b0;
    tick = 1'b0;
    ovf_evt = 1'b0;
    top = 16'h0000;
    s_nxt = s_r;
    // A write lands at the edge where waitrequest is seen low.
    wr = av_req.write && s_r.ack;
    rd = av_req.read && !s_r.ack;
    halted = s_r.halt_sync[1];
    s_nxt.ack = (av_req.read || av_req.write) && !s_r.ack;
    // Synchronisers: only the second stage is read by logic.
    s_nxt.ext_sync = {s_r.ext_sync[0], ext_clk};
    s_nxt.ext_prev = s_r.ext_sync[1];
    s_nxt.fix_sync = {s_r.fix_sync[0], fixed_clk_en};
    s_nxt.halt_sync = {s_r.halt_sync[0], debug_halt_mode};
    // Source select feeding the prescaler.
    case (s_r.sc.clks)
      `TMR_CLKS_OFF: src_en = 1'b0;
      `TMR_CLKS_BUS: src_en = 1'b1;
      `TMR_CLKS_FIX: src_en = loop_enabled ? s_r.fix_sync[1] : 1'b1;
      `TMR_CLKS_EXT: src_en = s_r.ext_sync[1] && !s_r.ext_prev;
      default: src_en = 1'b0;
    endcase
    src_en = src_en && !halted;
    // Prescaler uses the registered ps, so a write acts next cycle.
    tick = src_en && pre_tick(s_r.pre, s_r.sc.ps);
    if (src_en) begin
      s_nxt.pre = s_r.pre + 7'h01;
    end
    top = (modulo_value == 16'h0000) ? 16'hFFFF : modulo_value;
    ovf_evt = 1'b0;
    if (tick) begin
      if (s_r.sc.cpwm) begin
        if (!s_r.dir_down) begin
          if (s_r.cnt >= top) begin
            s_nxt.dir_down = 1'b1;
            s_nxt.cnt = s_r.cnt - 16'h0001;
            ovf_evt = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end else if (s_r.cnt == 16'h0000) begin
          s_nxt.dir_down = 1'b0;
          s_nxt.cnt = 16'h0001;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end else begin
        s_nxt.dir_down = 1'b0;
        if (s_r.cnt >= top) begin
          s_nxt.cnt = `TMR_CNT_RESET;
          ovf_evt = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
    end
    // Reads: status read while flag set arms the clear sequence.
    s_nxt.rdata = 32'h0000_0000;
    if (rd) begin
      case (av_req.address)
        `TMR_ADDR_SC: begin
          s_nxt.rdata = {24'h0, s_r.sc};
          if (s_r.sc.ovf) begin
            s_nxt.armed = 1'b1;
          end
        end
        `TMR_ADDR_CNTH, `TMR_ADDR_CNTL: begin
          if (s_r.lstate == LATCH_IDLE) begin
            s_nxt.rdata = (av_req.address == `TMR_ADDR_CNTH) ?
              {24'h0, s_r.cnt[15:8]} : {24'h0, s_r.cnt[7:0]};
            if (!halted) begin
              s_nxt.hold = s_r.cnt;
              s_nxt.lstate = LATCH_HELD;
            end
          end else begin
            s_nxt.rdata = (av_req.address == `TMR_ADDR_CNTH) ?
              {24'h0, s_r.hold[15:8]} : {24'h0, s_r.hold[7:0]};
            if (!halted) begin
              s_nxt.lstate = LATCH_IDLE;
            end
          end
        end
        `TMR_ADDR_IRQ: s_nxt.rdata = {30'h0, s_r.mask_ovf, s_r.st_ovf};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Writes.
    if (wr) begin
      case (av_req.address)
        `TMR_ADDR_SC: begin
          s_nxt.sc.ovie = av_req.writedata[`TMR_BIT_OVIE];
          s_nxt.sc.cpwm = av_req.writedata[`TMR_BIT_CPWM];
          s_nxt.sc.clks =
            av_req.writedata[`TMR_BIT_CLKS_HI:`TMR_BIT_CLKS_LO];
          s_nxt.sc.ps = av_req.writedata[`TMR_BIT_PS_HI:0];
          if (s_r.armed && !av_req.writedata[`TMR_BIT_OVF]) begin
            s_nxt.sc.ovf = 1'b0;
          end
          s_nxt.armed = 1'b0;
          s_nxt.lstate = LATCH_IDLE;
        end
        `TMR_ADDR_CNTH, `TMR_ADDR_CNTL: begin
          s_nxt.cnt = `TMR_CNT_RESET;
          s_nxt.dir_down = 1'b0;
          s_nxt.lstate = LATCH_IDLE;
        end
        `TMR_ADDR_IRQ: begin
          s_nxt.mask_ovf = av_req.writedata[1];
          if (av_req.writedata[0]) begin
            s_nxt.st_ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // A fresh overflow wins over any clear and disarms the sequence.
    if (ovf_evt) begin
      s_nxt.sc.ovf = 1'b1;
      s_nxt.armed = 1'b0;
      s_nxt.st_ovf = 1'b1;
    end
  end

  //----------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------
  // Reset clears flag, enables and counter; all take constants.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.sc <= `TMR_SC_RESET;
      s_r.lstate <= LATCH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  // Waitrequest is high only in the first cycle of each request.
  assign av_rsp.waitrequest = (av_req.read || av_req.write) && !s_r.ack;
  assign av_rsp.readdata = s_r.rdata;
  assign count_value = s_r.cnt;
  assign count_down = s_r.dir_down;
  assign center_align_select = s_r.sc.cpwm;
  assign counter_enabled = (s_r.sc.clks != `TMR_CLKS_OFF);
  // Either the classic enable or the mask path raises the line.
  assign irq = (s_r.sc.ovf && s_r.sc.ovie) ||
               (s_r.st_ovf && s_r.mask_ovf);
endmodule : timer_counter_status_control

//--- verilog/tmr_cfg.svh
// Register offsets, field positions, reset values and clock source codes.
//------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------
// Functional notes
// - Set overflow flag when counter wraps after modulo.
// - Clear flag by read-while-set then write zero.
// - New overflow during clear sequence restarts it.
// - Writing one leaves flag; reset clears flag.
// - Interrupt when flag and enable set.
// - Center-align select gives up/down counting.
// - Clock source field: off, bus, fixed, external.
// - Fixed clock without locked loop equals bus.
// - External clock synchronised here; fixed arrives synced but also passes through fix_sync here.
// - Prescaler divides by two to field power.
// - New prescale acts the following cycle.
// - Byte read latches both counter bytes coherently.
// - Status write or reset idles read latch.
// - Counter byte write zeroes counter and idles read latch.
// - Debug halt freezes counter and read latch.
// - Writes during halt still reset read latch.
// - Restart at zero after modulo; zero modulo free-runs.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_ADDR_SC 2'h0
`define TMR_ADDR_CNTH 2'h1
`define TMR_ADDR_CNTL 2'h2
`define TMR_ADDR_IRQ 2'h3
`define TMR_BIT_OVF 7
`define TMR_BIT_OVIE 6
`define TMR_BIT_CPWM 5
`define TMR_BIT_CLKS_HI 4
`define TMR_BIT_CLKS_LO 3
`define TMR_BIT_PS_HI 2
`define TMR_SC_RESET 8'h00
`define TMR_CNT_RESET 16'h0000
`define TMR_CLKS_OFF 2'h0
`define TMR_CLKS_BUS 2'h1
`define TMR_CLKS_FIX 2'h2
`define TMR_CLKS_EXT 2'h3
`endif

//--- verilog/tmr_pkg.sv
// Types shared by the timer counter block.
package tmr_pkg;
  typedef enum logic [1:0] {LATCH_IDLE, LATCH_HELD} latch_state_t;
  typedef struct packed {
    logic [1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } av_rsp_t;
  typedef struct packed {
    logic ovf;
    logic ovie;
    logic cpwm;
    logic [1:0] clks;
    logic [2:0] ps;
  } sc_t;
  typedef struct packed {
    sc_t sc;
    logic [15:0] cnt;
    logic dir_down;
    logic [6:0] pre;
    logic armed;
    latch_state_t lstate;
    logic [15:0] hold;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] fix_sync;
    logic [1:0] halt_sync;
    logic ack;
    logic [31:0] rdata;
    logic st_ovf;
    logic mask_ovf;
  } state_t;
endpackage : tmr_pkg
